// ---- rtl/ddrb_pkg.sv ----
// Purpose: Constants and types for the DDR2 bank command and state tracker
// Assumes: Commands come from logic on the same 50 MHz clock
// Notes: Register map, bank and power state codes, timing counts
//
// Summary of operation
// - Action depends on clock enable now, clock enable before, state and command.
// - Self refresh entry only with every bank idle.
// - Termination input never steers transitions; termination off in self refresh.
// - No refresh in power-down; controller limits power-down time.
// - Write beat stored when mask low, dropped when mask high.
// - Idle bank: activate, precharge, refresh, mode set legal; read, write rejected.
// - Active bank: read, write, precharge legal; activate, refresh, mode set illegal.
// - Burst runs out on no-op; only same-direction command interrupts, and only a burst without auto-precharge.
// - Precharging bank idles after precharge period; only precharge also legal.
// - Activating bank becomes active after delay; every other command illegal.
// - Command illegal for one bank may go to other banks.
// - Interrupt only at burst eight, by read or write, on four-beat boundary.
// - Power-down left on edge where clock enable high with no-op or deselect.

package ddrb_pkg;

   // ------------------------------------------------------------
   // Command and state codes
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      CMD_DESEL = 3'h0,
      CMD_NOP = 3'h1,
      CMD_ACT = 3'h2,
      CMD_PRE = 3'h3,
      CMD_READ = 3'h4,
      CMD_WRITE = 3'h5,
      CMD_MRS = 3'h6,
      CMD_REF = 3'h7
   } ddrb_cmd_t;

   typedef enum logic [2:0]
   {
      BK_IDLE = 3'h0,
      BK_ACTV = 3'h1,
      BK_ACTIVE = 3'h2,
      BK_READ = 3'h3,
      BK_WRITE = 3'h4,
      BK_READ_AP = 3'h5,
      BK_WRITE_AP = 3'h6,
      BK_PRE = 3'h7
   } ddrb_bank_t;

   typedef enum logic [1:0]
   {
      PW_NORMAL = 2'h0,
      PW_PDOWN = 2'h1,
      PW_SREF = 2'h2
   } ddrb_pwr_t;

   typedef struct packed
   {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [2:0] ba;
      logic a10;
   } ddrb_pins_t;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [3:0] REG_CFG = 4'h0;
   localparam logic [3:0] REG_TIMING = 4'h1;
   localparam logic [3:0] REG_STATUS = 4'h2;
   localparam logic [3:0] REG_BANKS = 4'h3;
   localparam int CFG_BL8_BIT = 0;
   localparam int CFG_ODT_BIT = 1;
   localparam logic [1:0] CFG_RST = 2'h3;
   localparam int TIM_RCD_LSB = 0;
   localparam int TIM_RP_LSB = 4;
   localparam int TIM_MRD_LSB = 8;
   localparam int TIM_RFC_LSB = 12;
   localparam logic [19:0] TIM_RST = 20'h1a233;
   localparam int ST_ILL_BIT = 4;
   localparam int ST_CKE_BIT = 5;
   localparam int ST_XRD_BIT = 6;

   // ------------------------------------------------------------
   // Timing counts in clocks
   // ------------------------------------------------------------
   localparam logic [7:0] XSRD_CLKS = 8'hc8;
   localparam logic [7:0] XSNR_CLKS = 8'h8c;
   localparam logic [1:0] CKE_HOLD_CLKS = 2'h3;
   localparam logic [3:0] BURST_BL4 = 4'h2;
   localparam logic [3:0] BURST_BL8 = 4'h4;
   localparam logic [3:0] BURST_HALF = 4'h2;

endpackage

// ---- rtl/ddrb_core.sv ----
// Purpose: DDR2 per-bank command legality and power state tracking
// Assumes: Command pins sampled on clk_in from same-clock logic
// Notes: Illegal commands leave power state and refusing banks unchanged and pulse illegal_out; other banks still act on a precharge-all
//
// Strobed register access and the address map were left to the implementer.

`timescale 1ns/100ps
`default_nettype none

module ddrb_core #(
   parameter int NUM_BANKS = 8,
   parameter int DATA_W = 16,
   parameter int MASK_W = 2
) (
   input wire logic clk_in, // 50 MHz clock
   input wire logic reset_n_in, // Async reset, active low
   input wire ddrb_pkg::ddrb_pins_t pins_in, // Command pins at this edge
   input wire logic odt_in, // Termination control
   input wire logic beat_valid_in, // Write data beat present
   input wire logic [DATA_W-1:0] beat_data_in, // Write data beat
   input wire logic [MASK_W-1:0] beat_mask_in, // Write mask per byte
   input wire logic [3:0] addr_in, // Register address
   input wire logic [31:0] wdata_in, // Register write data
   input wire logic wr_in, // Register write strobe
   input wire logic rd_in, // Register read strobe
   output logic [31:0] rdata_out, // Register read data
   output logic [3*NUM_BANKS-1:0] bank_state_out, // Per bank state codes
   output logic [1:0] power_state_out, // Power state code
   output logic illegal_out, // Pulse on illegal command
   output logic odt_active_out, // Termination active
   output logic [DATA_W-1:0] wr_data_out, // Stored write beat
   output logic [MASK_W-1:0] wr_be_out // Byte enables of stored beat
);
   import ddrb_pkg::*;

   if (NUM_BANKS != 8 || DATA_W != 8 * MASK_W)
   begin : g_chk
      $error("ddrb_core: unsupported bank count or data width");
   end

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   ddrb_cmd_t cmd;
   logic nop_like;
   logic bank_cmd;
   always_comb
   begin
      cmd = CMD_DESEL;
      if (!pins_in.cs_n)
      begin
         // Row, column and write-enable strobes taken as they stand on the pins
         case ({pins_in.ras_n, pins_in.cas_n, pins_in.we_n})
            3'h0: cmd = CMD_MRS;
            3'h1: cmd = CMD_REF;
            3'h2: cmd = CMD_PRE;
            3'h3: cmd = CMD_ACT;
            3'h4: cmd = CMD_WRITE;
            3'h5: cmd = CMD_READ;
            default: cmd = CMD_NOP;
         endcase
      end
      nop_like = (cmd == CMD_DESEL) || (cmd == CMD_NOP);
      bank_cmd = (cmd == CMD_ACT) || (cmd == CMD_PRE) || (cmd == CMD_READ)
         || (cmd == CMD_WRITE);
   end

   logic [1:0] cfg;
   logic [19:0] tim;
   logic st_ill;
   logic st_cke;
   ddrb_pwr_t pwr;
   logic cke_prev;
   logic [7:0] dev_cnt;
   logic [7:0] xsnr_cnt;
   logic [7:0] xsrd_cnt;
   logic [1:0] hold_cnt;
   ddrb_bank_t bk_st [NUM_BANKS];
   logic [3:0] bk_cnt [NUM_BANKS];
   logic [NUM_BANKS-1:0] hit;
   logic [NUM_BANKS-1:0] bk_ill;
   logic [NUM_BANKS-1:0] bk_idle;
   logic [NUM_BANKS-1:0] bk_busy;
   logic [NUM_BANKS-1:0] bk_wr;
   logic run_edge;
   logic dev_ok;
   logic [3:0] blen;
   always_comb
   begin
      run_edge = cke_prev && pins_in.cke && (pwr == PW_NORMAL);
      dev_ok = (dev_cnt == 8'h0) && (xsnr_cnt == 8'h0)
         && !((cmd == CMD_READ) && (xsrd_cnt != 8'h0));
      blen = cfg[CFG_BL8_BIT] ? BURST_BL8 : BURST_BL4;
   end

   // ------------------------------------------------------------
   // Per bank state and timer
   // ------------------------------------------------------------
   genvar gi;
   for (gi = 0; gi < NUM_BANKS; gi++)
   begin : g_bank
      ddrb_bank_t next_st;
      logic [3:0] next_cnt;
      logic same_dir;
      always_comb
      begin
         next_st = bk_st[gi];
         next_cnt = bk_cnt[gi];
         bk_ill[gi] = 1'b0;
         // Targeted only by its own address or a precharge-all
         hit[gi] = run_edge && dev_ok && bank_cmd && ((pins_in.ba == 3'(gi))
            || ((cmd == CMD_PRE) && pins_in.a10));
         same_dir = ((bk_st[gi] == BK_READ) && (cmd == CMD_READ))
            || ((bk_st[gi] == BK_WRITE) && (cmd == CMD_WRITE));
         if (bk_cnt[gi] != 4'h0)
            next_cnt = bk_cnt[gi] - 4'h1;
         unique case (bk_st[gi])
            BK_IDLE:
               if (hit[gi])
               begin
                  if (cmd == CMD_ACT)
                  begin
                     next_st = BK_ACTV;
                     next_cnt = tim[TIM_RCD_LSB+:4];
                  end
                  else if (cmd != CMD_PRE)
                     bk_ill[gi] = 1'b1;
               end
            BK_ACTV:
               if (hit[gi])
                  bk_ill[gi] = 1'b1;
               else if (bk_cnt[gi] <= 4'h1)
                  next_st = BK_ACTIVE;
            BK_ACTIVE:
               if (hit[gi])
               begin
                  if (cmd == CMD_READ || cmd == CMD_WRITE)
                  begin
                     next_cnt = blen;
                     if (cmd == CMD_READ)
                        next_st = pins_in.a10 ? BK_READ_AP : BK_READ;
                     else
                        next_st = pins_in.a10 ? BK_WRITE_AP : BK_WRITE;
                  end
                  else if (cmd == CMD_PRE)
                  begin
                     next_st = BK_PRE;
                     next_cnt = tim[TIM_RP_LSB+:4];
                  end
                  else
                     bk_ill[gi] = 1'b1;
               end
            BK_READ, BK_WRITE, BK_READ_AP, BK_WRITE_AP:
               if (hit[gi])
               begin
                  // Four-beat boundary is two cycles in, one above the half count
                  if (same_dir && cfg[CFG_BL8_BIT]
                     && (bk_cnt[gi] == BURST_BL8 - BURST_HALF + 4'h1))
                  begin
                     next_cnt = blen;
                     if (cmd == CMD_READ)
                        next_st = pins_in.a10 ? BK_READ_AP : BK_READ;
                     else
                        next_st = pins_in.a10 ? BK_WRITE_AP : BK_WRITE;
                  end
                  else
                     bk_ill[gi] = 1'b1;
               end
               else if (bk_cnt[gi] <= 4'h1)
               begin
                  if (bk_st[gi] == BK_READ || bk_st[gi] == BK_WRITE)
                     next_st = BK_ACTIVE;
                  else
                  begin
                     next_st = BK_PRE;
                     next_cnt = tim[TIM_RP_LSB+:4];
                  end
               end
            BK_PRE:
               if (hit[gi] && cmd != CMD_PRE)
                  bk_ill[gi] = 1'b1;
               else if (bk_cnt[gi] <= 4'h1)
                  next_st = BK_IDLE;
         endcase
         bk_idle[gi] = (bk_st[gi] == BK_IDLE);
         bk_busy[gi] = (bk_st[gi] != BK_IDLE) && (bk_st[gi] != BK_ACTIVE);
         bk_wr[gi] = (bk_st[gi] == BK_WRITE) || (bk_st[gi] == BK_WRITE_AP);
      end

      always_ff @(posedge clk_in or negedge reset_n_in)
      begin
         if (!reset_n_in)
         begin
            bk_st[gi] <= BK_IDLE;
            bk_cnt[gi] <= 4'h0;
         end
         else
         begin
            bk_st[gi] <= next_st;
            bk_cnt[gi] <= next_cnt;
         end
      end
   end

   // ------------------------------------------------------------
   // Device power state and exit waits
   // ------------------------------------------------------------
   ddrb_pwr_t next_pwr;
   logic [7:0] next_dev_cnt;
   logic [7:0] next_xsnr;
   logic [7:0] next_xsrd;
   logic [1:0] next_hold;
   logic dev_ill;
   logic cke_viol;
   logic all_idle;
   always_comb
   begin
      next_pwr = pwr;
      next_dev_cnt = (dev_cnt != 8'h0) ? dev_cnt - 8'h1 : dev_cnt;
      next_xsnr = (xsnr_cnt != 8'h0) ? xsnr_cnt - 8'h1 : xsnr_cnt;
      next_xsrd = (xsrd_cnt != 8'h0) ? xsrd_cnt - 8'h1 : xsrd_cnt;
      next_hold = (hold_cnt != 2'h0) ? hold_cnt - 2'h1 : hold_cnt;
      dev_ill = 1'b0;
      cke_viol = 1'b0;
      all_idle = &bk_idle;
      if (pins_in.cke != cke_prev)
      begin
         cke_viol = (hold_cnt != 2'h0);
         next_hold = CKE_HOLD_CLKS - 2'h1;
      end
      unique case (pwr)
         PW_NORMAL:
            if (cke_prev && !pins_in.cke)
            begin
               if (cmd == CMD_REF && all_idle && dev_cnt == 8'h0)
                  next_pwr = PW_SREF;
               else if (nop_like && !(|bk_busy) && dev_cnt == 8'h0)
                  next_pwr = PW_PDOWN;
               else
                  dev_ill = 1'b1;
            end
            else if (run_edge)
            begin
               if (!dev_ok && !nop_like)
                  dev_ill = 1'b1;
               else if (cmd == CMD_REF || cmd == CMD_MRS)
               begin
                  // Refresh happens only here, never in power-down
                  if (!all_idle)
                     dev_ill = 1'b1;
                  else if (cmd == CMD_REF)
                     next_dev_cnt = tim[TIM_RFC_LSB+:8];
                  else
                     next_dev_cnt = 8'(tim[TIM_MRD_LSB+:4]);
               end
            end
         PW_PDOWN:
            if (pins_in.cke)
            begin
               if (nop_like)
                  next_pwr = PW_NORMAL;
               else
                  dev_ill = 1'b1;
            end
         PW_SREF:
            if (pins_in.cke)
            begin
               if (nop_like)
               begin
                  next_pwr = PW_NORMAL;
                  next_xsnr = XSNR_CLKS;
                  next_xsrd = XSRD_CLKS;
               end
               else
                  dev_ill = 1'b1;
            end
         default:
            next_pwr = PW_NORMAL;
      endcase
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         pwr <= PW_NORMAL;
         cke_prev <= 1'b0;
         dev_cnt <= 8'h0;
         xsnr_cnt <= 8'h0;
         xsrd_cnt <= 8'h0;
         hold_cnt <= 2'h0;
      end
      else
      begin
         pwr <= next_pwr;
         cke_prev <= pins_in.cke;
         dev_cnt <= next_dev_cnt;
         xsnr_cnt <= next_xsnr;
         xsrd_cnt <= next_xsrd;
         hold_cnt <= next_hold;
      end
   end

   // ------------------------------------------------------------
   // Registers and outputs
   // ------------------------------------------------------------
   logic [1:0] next_cfg;
   logic [19:0] next_tim;
   logic next_st_ill;
   logic next_st_cke;
   logic [31:0] next_rdata;
   logic any_ill;
   logic [3*NUM_BANKS-1:0] bank_vec;
   always_comb
   begin
      any_ill = dev_ill || (|bk_ill);
      next_cfg = cfg;
      next_tim = tim;
      next_st_ill = st_ill;
      next_st_cke = st_cke;
      for (int i = 0; i < NUM_BANKS; i++)
         bank_vec[3*i+:3] = bk_st[i];
      if (wr_in && addr_in == REG_CFG)
         next_cfg = wdata_in[1:0];
      if (wr_in && addr_in == REG_TIMING)
         next_tim = wdata_in[19:0];
      // Write one clears; a new event in the same cycle wins
      if (wr_in && addr_in == REG_STATUS && wdata_in[ST_ILL_BIT])
         next_st_ill = 1'b0;
      if (wr_in && addr_in == REG_STATUS && wdata_in[ST_CKE_BIT])
         next_st_cke = 1'b0;
      if (any_ill)
         next_st_ill = 1'b1;
      if (cke_viol)
         next_st_cke = 1'b1;
      next_rdata = 32'h0;
      if (rd_in)
      begin
         unique case (addr_in)
            REG_CFG: next_rdata = {30'h0, cfg};
            REG_TIMING: next_rdata = {12'h0, tim};
            REG_STATUS: next_rdata = {25'h0, xsrd_cnt != 8'h0, st_cke, st_ill, 2'h0, pwr};
            REG_BANKS: next_rdata = 32'(bank_vec);
            default: next_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         cfg <= CFG_RST;
         tim <= TIM_RST;
         st_ill <= 1'b0;
         st_cke <= 1'b0;
         rdata_out <= 32'h0;
         bank_state_out <= '0;
         power_state_out <= 2'h0;
         illegal_out <= 1'b0;
         odt_active_out <= 1'b0;
         wr_data_out <= '0;
         wr_be_out <= '0;
      end
      else
      begin
         cfg <= next_cfg;
         tim <= next_tim;
         st_ill <= next_st_ill;
         st_cke <= next_st_cke;
         rdata_out <= next_rdata;
         bank_state_out <= bank_vec;
         power_state_out <= pwr;
         illegal_out <= any_ill;
         odt_active_out <= odt_in && cfg[CFG_ODT_BIT] && (pwr != PW_SREF);
         wr_data_out <= beat_data_in;
         wr_be_out <= (beat_valid_in && (|bk_wr)) ? ~beat_mask_in : '0;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_act0;
      hit[0] && cmd == CMD_ACT && bk_st[0] == BK_IDLE;
   endsequence
   sequence s_pd_exit;
      pwr == PW_PDOWN && pins_in.cke && nop_like;
   endsequence

   a_act_opens_row: assert property (s_act0 |=> bk_st[0] == BK_ACTV)
      else $error("activate did not open row");
   a_rcd_hold: assert property (bk_st[0] == BK_ACTV && bk_cnt[0] > 4'h1 |=> bk_st[0] == BK_ACTV)
      else $error("row active before delay");
   a_pd_exit_sync: assert property (s_pd_exit |=> pwr == PW_NORMAL ##1 power_state_out == 2'h0)
      else $error("power-down exit missed");
   a_sref_idle_only: assert property (pwr != PW_SREF ##1 pwr == PW_SREF |-> $past(all_idle))
      else $error("self refresh entered with open bank");
   a_pre_to_idle: assert property (bk_st[0] == BK_PRE && bk_cnt[0] == 4'h1 && !hit[0] |=> bk_st[0] == BK_IDLE)
      else $error("precharge did not finish");
   a_idle_rw_reject: assert property (bk_st[0] == BK_IDLE && hit[0] && cmd == CMD_READ |=> illegal_out && bk_st[0] == BK_IDLE)
      else $error("read accepted in idle");
   a_bl4_no_interrupt: assert property (!cfg[CFG_BL8_BIT] && bk_st[0] == BK_READ && hit[0] |=> illegal_out)
      else $error("burst of four interrupted");
   a_burst_end: assert property (bk_st[0] == BK_WRITE && bk_cnt[0] == 4'h1 && !hit[0] |=> bk_st[0] == BK_ACTIVE)
      else $error("write burst did not end");
   a_odt_off_sref: assert property (pwr == PW_SREF |=> !odt_active_out)
      else $error("termination active in self refresh");
   a_mask_inhibit: assert property (beat_valid_in && beat_mask_in[0] |=> !wr_be_out[0])
      else $error("masked beat written");
   a_read_exit_wait: assert property (run_edge && cmd == CMD_READ && xsrd_cnt != 8'h0 |=> illegal_out)
      else $error("early read accepted");

endmodule

`default_nettype wire

// ---- verif/ddrb_ctrl_model.sv ----
// Purpose: Memory controller model that turns a command code into pins
// Assumes: Bench updates the request just after a rising edge
// Notes: Lines left idle under deselect toggle so no stale value lingers
`timescale 1ns/100ps
`default_nettype none
module ddrb_ctrl_model (
   input wire logic clk_in, // 50 MHz clock
   input wire ddrb_pkg::ddrb_cmd_t cmd_in, // Command to send
   input wire logic cke_in, // Clock enable level
   input wire logic [2:0] ba_in, // Target bank
   input wire logic a10_in, // All banks or auto-precharge
   output var ddrb_pkg::ddrb_pins_t pins_out // Command pins
);
   import ddrb_pkg::*;
   logic [6:0] junk = 7'h55;
   logic [6:0] next_junk;
   logic [2:0] rcw;
   always_comb
   begin
      next_junk = ~junk;
      case (cmd_in)
         CMD_ACT: rcw = 3'h3;
         CMD_PRE: rcw = 3'h2;
         CMD_READ: rcw = 3'h5;
         CMD_WRITE: rcw = 3'h4;
         CMD_MRS: rcw = 3'h0;
         CMD_REF: rcw = 3'h1;
         default: rcw = 3'h7;
      endcase
      // Deselected lines carry nothing, so they must not look stable
      if (cmd_in == CMD_DESEL)
         pins_out = {cke_in, 1'h1, junk};
      else
         pins_out = {cke_in, 1'h0, rcw, ba_in, a10_in};
   end
   always_ff @(posedge clk_in)
      junk <= next_junk;
endmodule
`default_nettype wire

// ---- verif/test_ddr2_bank_command_state_rules.sv ----
// Purpose: Self-checking bench for the bank command and state tracker
// Assumes: Default timing, activate delay 3, precharge period 3
// Notes: Each table row is followed by a settle of 40 no-op cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_ddr2_bank_command_state_rules;
   import ddrb_pkg::*;
   typedef struct packed
   {
      ddrb_cmd_t cmd;
      logic [2:0] ba;
      logic a10;
      logic ill;
      logic [2:0] st;
   } ddrb_row_t;
   logic clk_in = 1'h0;
   logic reset_n_in = 1'h0;
   ddrb_cmd_t cmd = CMD_NOP;
   logic cke = 1'h1;
   logic [2:0] ba = 3'h0;
   logic a10 = 1'h0;
   ddrb_pins_t pins;
   logic termination_control = 1'h0;
   logic bv = 1'h0;
   logic [15:0] bd = 16'h0;
   logic [1:0] bm = 2'h0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [31:0] rdata;
   logic [23:0] bank_st;
   logic [1:0] pwr;
   logic ill;
   logic odt_act;
   logic [15:0] wr_data;
   logic [1:0] wr_be;
   logic [31:0] d;
   int err_count = 0;
   int checked = 0;
   int ill_cnt = 0;
   ddrb_row_t rows [14] = '{
      '{CMD_READ, 3'h0, 1'h0, 1'h1, BK_IDLE}, '{CMD_WRITE, 3'h0, 1'h0, 1'h1, BK_IDLE},
      '{CMD_MRS, 3'h0, 1'h0, 1'h0, BK_IDLE}, '{CMD_REF, 3'h0, 1'h0, 1'h0, BK_IDLE},
      '{CMD_PRE, 3'h0, 1'h0, 1'h0, BK_IDLE}, '{CMD_ACT, 3'h0, 1'h0, 1'h0, BK_ACTIVE},
      '{CMD_ACT, 3'h0, 1'h0, 1'h1, BK_ACTIVE}, '{CMD_REF, 3'h0, 1'h0, 1'h1, BK_ACTIVE},
      '{CMD_MRS, 3'h0, 1'h0, 1'h1, BK_ACTIVE}, '{CMD_READ, 3'h0, 1'h0, 1'h0, BK_ACTIVE},
      '{CMD_WRITE, 3'h0, 1'h0, 1'h0, BK_ACTIVE}, '{CMD_PRE, 3'h0, 1'h0, 1'h0, BK_IDLE},
      '{CMD_ACT, 3'h1, 1'h0, 1'h0, BK_ACTIVE}, '{CMD_READ, 3'h1, 1'h1, 1'h0, BK_IDLE}};
   always #10 clk_in = ~clk_in;
   always @(posedge clk_in)
      if (ill === 1'h1)
         ill_cnt <= ill_cnt + 1;
   ddrb_ctrl_model ctrl (.clk_in(clk_in), .cmd_in(cmd), .cke_in(cke), .ba_in(ba),
      .a10_in(a10), .pins_out(pins));
   ddrb_core DUT (.clk_in(clk_in), .reset_n_in(reset_n_in), .pins_in(pins), .odt_in(termination_control),
      .beat_valid_in(bv), .beat_data_in(bd), .beat_mask_in(bm), .addr_in(addr),
      .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
      .bank_state_out(bank_st), .power_state_out(pwr), .illegal_out(ill),
      .odt_active_out(odt_act), .wr_data_out(wr_data), .wr_be_out(wr_be));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic complete_run();
      $display("checked=%0d err_count=%0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic issue(input ddrb_cmd_t c, input logic [2:0] b, input logic a, input logic k);
      @(posedge clk_in);
      cmd <= c;
      ba <= b;
      a10 <= a;
      cke <= k;
   endtask
   task automatic run(input ddrb_cmd_t c, input logic [2:0] b, input logic a,
      input logic e_ill, input logic [2:0] e_st);
      int n0;
      n0 = ill_cnt;
      issue(c, b, a, 1'h1);
      issue(CMD_NOP, 3'h0, 1'h0, 1'h1);
      repeat (40) @(posedge clk_in);
      #1;
      `CHK(ill_cnt != n0, e_ill)
      `CHK(bank_st[3*b +: 3], e_st)
   endtask
   task automatic pair(input ddrb_cmd_t c1, input ddrb_cmd_t c2, input int gap, input logic e);
      int n0;
      n0 = ill_cnt;
      issue(c1, 3'h0, 1'h0, 1'h1);
      repeat (gap) issue(CMD_NOP, 3'h0, 1'h0, 1'h1);
      issue(c2, 3'h0, 1'h0, 1'h1);
      issue(CMD_NOP, 3'h0, 1'h0, 1'h1);
      repeat (20) @(posedge clk_in);
      `CHK(ill_cnt != n0, e)
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk_in);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk_in);
      rd <= 1'h0;
      #1;
      d = rdata;
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk_in);
      addr <= a;
      wdata <= v;
      wr <= 1'h1;
      @(posedge clk_in);
      wr <= 1'h0;
   endtask
   // Holds the new clock enable level well past three registered edges
   task automatic cke_step(input ddrb_cmd_t c, input logic k);
      issue(c, 3'h0, 1'h0, k);
      issue(CMD_NOP, 3'h0, 1'h0, k);
      repeat (5) @(posedge clk_in);
      #1;
   endtask
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'h1;
      #1;
      `CHK(bank_st, 24'h0)
      repeat (2) @(posedge clk_in);
      rd_reg(4'h0);
      `CHK(d, 32'h3)
      rd_reg(4'h1);
      `CHK(d, 32'h1a233)
      wr_reg(4'h9, 32'h5);
      rd_reg(4'h9);
      `CHK(d, 32'h0)
      foreach (rows[i])
         run(rows[i].cmd, rows[i].ba, rows[i].a10, rows[i].ill, rows[i].st);
      run(CMD_ACT, 3'h0, 1'h0, 1'h0, BK_ACTIVE);
      pair(CMD_READ, CMD_WRITE, 1, 1'h1);
      pair(CMD_READ, CMD_READ, 1, 1'h0);
      pair(CMD_READ, CMD_READ, 0, 1'h1);
      pair(CMD_WRITE, CMD_WRITE, 1, 1'h0);
      wr_reg(4'h0, 32'h2);
      pair(CMD_READ, CMD_READ, 1, 1'h1);
      wr_reg(4'h0, 32'h3);
      issue(CMD_WRITE, 3'h0, 1'h0, 1'h1);
      issue(CMD_NOP, 3'h0, 1'h0, 1'h1);
      bv <= 1'h1;
      bd <= 16'hbeef;
      bm <= 2'h1;
      @(posedge clk_in);
      bv <= 1'h0;
      #1;
      `CHK(wr_be, 2'h2)
      `CHK(wr_data, 16'hbeef)
      rd_reg(4'h2);
      `CHK(d[ST_ILL_BIT], 1'h1)
      wr_reg(4'h2, 32'h10);
      rd_reg(4'h2);
      `CHK(d[ST_ILL_BIT], 1'h0)
      cke_step(CMD_REF, 1'h0);
      `CHK(pwr, PW_NORMAL)
      cke_step(CMD_NOP, 1'h1);
      run(CMD_PRE, 3'h0, 1'h1, 1'h0, BK_IDLE);
      cke_step(CMD_NOP, 1'h0);
      `CHK(pwr, PW_PDOWN)
      cke_step(CMD_NOP, 1'h1);
      `CHK(pwr, PW_NORMAL)
      termination_control <= 1'h1;
      cke_step(CMD_REF, 1'h0);
      `CHK(pwr, PW_SREF)
      `CHK(odt_act, 1'h0)
      cke_step(CMD_NOP, 1'h1);
      `CHK(pwr, PW_NORMAL)
      `CHK(odt_act, 1'h1)
      rd_reg(4'h2);
      `CHK(d[ST_XRD_BIT], 1'h1)
      `CHK(d[ST_CKE_BIT], 1'h0)
      run(CMD_ACT, 3'h0, 1'h0, 1'h1, BK_IDLE);
      // Lands between the end of the non-read wait and the end of the read wait
      repeat (100) @(posedge clk_in);
      run(CMD_ACT, 3'h0, 1'h0, 1'h0, BK_ACTIVE);
      run(CMD_READ, 3'h0, 1'h0, 1'h1, BK_ACTIVE);
      rd_reg(4'h2);
      `CHK(d[ST_XRD_BIT], 1'h0)
      run(CMD_READ, 3'h0, 1'h0, 1'h0, BK_ACTIVE);
      complete_run();
   end
   initial
   begin
      repeat (6000) @(posedge clk_in);
      err_count++;
      complete_run();
   end
endmodule
`default_nettype wire
